/* File: hdl/pscap_pkg.sv */
// pscap_pkg: offsets, field layout, reset values and carrier types
// of the slot capabilities register bank.
// assumes a 12-bit byte address from the register port.
package pscap_pkg;

   // --------------------------------------------------------------
   // register offsets
   // --------------------------------------------------------------
   localparam int          ADDR_W    = 12;
   localparam logic [11:0] CAP_OFF   = 12'h054;
   localparam logic [11:0] CTL_OFF   = 12'h0F0;
   localparam logic [11:0] STS_OFF   = 12'h0F4;

   // --------------------------------------------------------------
   // field positions
   // --------------------------------------------------------------
   localparam int PRESENT_LSB = 0;
   localparam int PRESENT_W   = 7;
   localparam int VALUE_LSB   = 7;
   localparam int VALUE_W     = 8;
   localparam int SCALE_LSB   = 15;
   localparam int SCALE_W     = 2;
   localparam int INTLK_BIT   = 17;
   localparam int NOCMD_BIT   = 18;
   localparam int SLOTNUM_LSB = 19;
   localparam int SLOTNUM_W   = 13;
   localparam int UNLOCK_BIT  = 0;
   localparam int STS_PEND    = 0;
   localparam int STS_BUSY    = 1;
   localparam int STS_LINK    = 2;
   localparam int STS_OPEN    = 3;

   // --------------------------------------------------------------
   // reset values
   // --------------------------------------------------------------
   localparam logic [31:0] CAP_RST    = 32'h0000_0000;
   localparam logic        UNLOCK_RST = 1'h0;
   localparam logic        NOCMD_VAL  = 1'h0;

   // --------------------------------------------------------------
   // types
   // --------------------------------------------------------------
   typedef enum logic [1:0] {
      SCALE_X1    = 2'h0,
      SCALE_XP1   = 2'h1,
      SCALE_XP01  = 2'h2,
      SCALE_XP001 = 2'h3
   } pscap_scale_type;

   // layout matches the register bit for bit, msb first
   typedef struct packed {
      logic [SLOTNUM_W-1:0] physical_slot_number;
      logic                 no_cmd_done_support;
      logic                 interlock_present;
      pscap_scale_type      power_limit_scale;
      logic [VALUE_W-1:0]   power_limit_value;
      logic                 hotplug_capable;
      logic                 surprise_removal;
      logic                 power_indicator_present;
      logic                 attn_indicator_present;
      logic                 latch_sensor_present;
      logic                 power_ctrl_present;
      logic                 attn_button_present;
   } pscap_cap_type;

   typedef struct packed {
      pscap_scale_type    scale;
      logic [VALUE_W-1:0] value;
   } pscap_msg_type;

endpackage : pscap_pkg

/* File: hdl/pscap_msg_gen.sv */
// pscap_msg_gen: launches power limit messages toward the link.
// assumes the link side holds msg_ready high to accept a message.
`timescale 1ns/100ps
module pscap_msg_gen
(
   input  wire logic                    clk,
   input  wire logic                    nrst,
   input  wire logic                    trigger,
   input  wire pscap_pkg::pscap_msg_type fields,
   input  wire logic                    msg_ready,
   output logic                         msg_valid,
   output pscap_pkg::pscap_msg_type     msg_data,
   output logic                         pending
);

   typedef enum logic {
      PSCAP_IDLE = 1'b0,
      PSCAP_SEND = 1'b1
   } pscap_state_type;

   pscap_state_type          state_reg;
   pscap_state_type          state_next;
   logic                     pend_reg;
   pscap_pkg::pscap_msg_type data_reg;
   wire                      launch;
   wire                      done;

   // --------------------------------------------------------------
   // sequencing
   // --------------------------------------------------------------
   assign launch = (state_reg == PSCAP_IDLE) & pend_reg;
   assign done   = (state_reg == PSCAP_SEND) & msg_ready;

   always_comb
   begin
      case (state_reg)
         PSCAP_IDLE: state_next = pend_reg ? PSCAP_SEND : PSCAP_IDLE;
         PSCAP_SEND: state_next = msg_ready ? PSCAP_IDLE : PSCAP_SEND;
         default:    state_next = PSCAP_IDLE;
      endcase
   end

   // a trigger landing while a request is taken keeps it pending
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_reg <= PSCAP_IDLE;
         pend_reg  <= 1'b0;
         data_reg  <= '0;
      end
      else
      begin
         state_reg <= state_next;
         pend_reg  <= trigger | (pend_reg & ~launch);
         if (launch)
            data_reg <= fields;
      end
   end

   assign msg_valid = (state_reg == PSCAP_SEND);
   assign msg_data  = data_reg;
   assign pending   = pend_reg;

   a_msg_held_stable : assert property (@(posedge clk) disable iff (!nrst)
      msg_valid && !msg_ready |=> msg_valid && $stable(msg_data))
      else $error("message dropped or changed before acceptance");

   a_msg_done_idle : assert property (@(posedge clk) disable iff (!nrst)
      done && !pend_reg |=> !msg_valid)
      else $error("message not ended after acceptance");

endmodule : pscap_msg_gen

/* File: hdl/pscap_regs.sv */
// pscap_regs: slot capabilities register of one downstream port.
// assumes a single-cycle register port and a synchronous link state.
`timescale 1ns/100ps
module pscap_regs
(
   input  wire logic                            clk,
   input  wire logic                            nrst,
   input  wire logic [pscap_pkg::ADDR_W-1:0]    addr,
   input  wire logic [31:0]                     wdata,
   input  wire logic                            wr,
   input  wire logic                            rd,
   output logic      [31:0]                     rdata,
   input  wire logic                            slot_implemented,
   input  wire logic                            cfg_init,
   input  wire logic                            dl_up,
   input  wire logic                            msg_ready,
   output logic                                 msg_valid,
   output pscap_pkg::pscap_msg_type             msg_data
);

   // --------------------------------------------------------------
   // state
   // --------------------------------------------------------------
   pscap_pkg::pscap_cap_type cap_reg;
   pscap_pkg::pscap_cap_type cap_next;
   logic                     unlock_reg;
   logic                     dl_up_reg;
   logic [31:0]              rdata_reg;
   logic [31:0]              rdata_next;

   // --------------------------------------------------------------
   // decode
   // --------------------------------------------------------------
   wire                      sel_cap;
   wire                      sel_ctl;
   wire                      sel_sts;
   wire                      wr_cap;
   wire                      lock_open;
   wire                      wr_locked;
   wire                      link_rise;
   wire                      send_req;
   wire                      pending;
   pscap_pkg::pscap_cap_type wcap;
   pscap_pkg::pscap_cap_type cap_view;
   pscap_pkg::pscap_msg_type live_msg;
   wire [31:0]               ctl_word;
   wire [31:0]               sts_word;

   // read image: whole word zero without a slot, bit 18 always zero
   function automatic pscap_pkg::pscap_cap_type view_of(
      input pscap_pkg::pscap_cap_type cap,
      input logic                     slot);
      pscap_pkg::pscap_cap_type v;
      v                     = slot ? cap : pscap_pkg::pscap_cap_type'(32'h0);
      v.no_cmd_done_support = pscap_pkg::NOCMD_VAL;
      return v;
   endfunction : view_of

   assign sel_cap   = (addr == pscap_pkg::CAP_OFF);
   assign sel_ctl   = (addr == pscap_pkg::CTL_OFF);
   assign sel_sts   = (addr == pscap_pkg::STS_OFF);
   assign wr_cap    = wr & sel_cap & slot_implemented;
   assign lock_open = cfg_init | unlock_reg;
   assign wr_locked = wr_cap & lock_open;
   assign wcap      = pscap_pkg::pscap_cap_type'(wdata);
   assign cap_view  = view_of(cap_reg, slot_implemented);
   assign link_rise = dl_up & ~dl_up_reg;
   assign send_req  = wr_cap | (link_rise & slot_implemented);

   // --------------------------------------------------------------
   // field update
   // --------------------------------------------------------------
   always_comb
   begin
      cap_next = cap_reg;
      if (wr_locked)
      begin
         cap_next.attn_button_present     = wcap.attn_button_present;
         cap_next.power_ctrl_present      = wcap.power_ctrl_present;
         cap_next.latch_sensor_present    = wcap.latch_sensor_present;
         cap_next.attn_indicator_present  = wcap.attn_indicator_present;
         cap_next.power_indicator_present = wcap.power_indicator_present;
         cap_next.surprise_removal        = wcap.surprise_removal;
         cap_next.hotplug_capable         = wcap.hotplug_capable;
         cap_next.interlock_present       = wcap.interlock_present;
         cap_next.physical_slot_number    = wcap.physical_slot_number;
      end
      if (wr_cap)
      begin
         cap_next.power_limit_value = wcap.power_limit_value;
         cap_next.power_limit_scale = wcap.power_limit_scale;
      end
      cap_next.no_cmd_done_support = pscap_pkg::NOCMD_VAL;
   end

   // --------------------------------------------------------------
   // read mux
   // --------------------------------------------------------------
   assign ctl_word = {31'h0, unlock_reg};
   assign sts_word = {28'h0, lock_open, dl_up_reg, msg_valid, pending};

   always_comb
   begin
      rdata_next = 32'h0;
      if (rd && sel_cap)
         rdata_next = 32'(cap_view);
      else if (rd && sel_ctl)
         rdata_next = ctl_word;
      else if (rd && sel_sts)
         rdata_next = sts_word;
   end

   // --------------------------------------------------------------
   // registers
   // --------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cap_reg    <= pscap_pkg::pscap_cap_type'(pscap_pkg::CAP_RST);
         unlock_reg <= pscap_pkg::UNLOCK_RST;
         dl_up_reg  <= 1'b0;
         rdata_reg  <= 32'h0;
      end
      else
      begin
         cap_reg   <= cap_next;
         dl_up_reg <= dl_up;
         rdata_reg <= rdata_next;
         if (wr && sel_ctl)
            unlock_reg <= wdata[pscap_pkg::UNLOCK_BIT];
      end
   end

   assign rdata = rdata_reg;

   // --------------------------------------------------------------
   // power limit message
   // --------------------------------------------------------------
   assign live_msg = {cap_reg.power_limit_scale,
                      cap_reg.power_limit_value};

   pscap_msg_gen u_msg
   (
      .clk       (clk),
      .nrst      (nrst),
      .trigger   (send_req),
      .fields    (live_msg),
      .msg_ready (msg_ready),
      .msg_valid (msg_valid),
      .msg_data  (msg_data),
      .pending   (pending)
   );

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   a_noslot_reads_zero : assert property (@(posedge clk) disable iff (!nrst)
      rd && sel_cap && !slot_implemented |=> rdata == 32'h0)
      else $error("capabilities visible without a slot");

   a_noslot_write_lost : assert property (@(posedge clk) disable iff (!nrst)
      wr && sel_cap && !slot_implemented |=> $stable(cap_reg))
      else $error("write taken without a slot");

   a_nocmd_bit_zero : assert property (@(posedge clk) disable iff (!nrst)
      rd && sel_cap |=> !rdata[pscap_pkg::NOCMD_BIT])
      else $error("no command completed bit set");

   a_present_readback : assert property (@(posedge clk) disable iff (!nrst)
      rd && sel_cap && slot_implemented
      |=> rdata[6:0] == $past(cap_reg[6:0]))
      else $error("presence bits read back wrong");

   a_interlock_read : assert property (@(posedge clk) disable iff (!nrst)
      rd && sel_cap && slot_implemented
      |=> rdata[pscap_pkg::INTLK_BIT] == $past(cap_reg.interlock_present))
      else $error("interlock bit read back wrong");

   a_locked_hold : assert property (@(posedge clk) disable iff (!nrst)
      wr_cap && !lock_open
      |=> $stable(cap_reg[6:0]) && $stable(cap_reg.physical_slot_number))
      else $error("locked field written while locked");

   a_value_write : assert property (@(posedge clk) disable iff (!nrst)
      wr_cap |=> cap_reg.power_limit_value == $past(wdata[14:7]))
      else $error("power limit value not written");

   a_scale_write : assert property (@(posedge clk) disable iff (!nrst)
      wr_cap |=> cap_reg.power_limit_scale == $past(wdata[16:15]))
      else $error("power limit scale not written");

   a_msg_on_write : assert property (@(posedge clk) disable iff (!nrst)
      wr_cap && !msg_valid && !pending
      |-> ##2 msg_valid && msg_data.value == $past(wdata[14:7], 2))
      else $error("no message after register write");

   a_msg_on_linkup : assert property (@(posedge clk) disable iff (!nrst)
      link_rise && slot_implemented && !msg_valid && !pending
      |-> ##2 msg_valid)
      else $error("no message after link up");

endmodule : pscap_regs

/* File: testbench/pscap_link_model.sv */
// pscap_link_model: behavioural link partner taking power limit messages.
// assumes msg_valid and msg_data hold until an edge with msg_ready high.
`timescale 1ns/100ps
module pscap_link_model
(
   input  wire logic                     clk,
   input  wire logic                     nrst,
   input  wire logic                     slow,
   input  wire logic                     msg_valid,
   input  wire pscap_pkg::pscap_msg_type msg_data,
   output logic                          msg_ready,
   output int                            n_msg,
   output pscap_pkg::pscap_msg_type      last_msg
);
   logic [1:0] pace_reg;

   // slow partner only takes a message one cycle in four
   assign msg_ready = !slow || (pace_reg == 2'h3);

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pace_reg <= 2'h0;
         n_msg    <= 0;
         last_msg <= '0;
      end
      else
      begin
         pace_reg <= pace_reg + 2'h1;
         if (msg_valid && msg_ready)
         begin
            n_msg    <= n_msg + 1;
            last_msg <= msg_data;
         end
      end
   end
endmodule : pscap_link_model

/* File: testbench/tb.sv */
// tb: self-checking bench of the slot capabilities register bank.
// assumes the register port answers reads in the cycle after rd.
`timescale 1ns/100ps
module tb;
   logic                     clk;
   logic                     nrst;
   logic [11:0]              addr;
   logic [31:0]              wdata;
   logic                     wr;
   logic                     rd;
   logic [31:0]              rdata;
   logic                     slot;
   logic                     cfg;
   logic                     dl;
   logic                     slow;
   logic                     msg_ready;
   logic                     msg_valid;
   pscap_pkg::pscap_msg_type msg_data;
   pscap_pkg::pscap_msg_type last_msg;
   int                       n_msg;
   int                       err_count;
   int                       n_checks;
   int                       cyc;
   int                       seed;
   int                       n0;
   logic [31:0]              mdl;
   logic [31:0]              w;

   pscap_regs uut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .slot_implemented(slot), .cfg_init(cfg), .dl_up(dl),
      .msg_ready(msg_ready), .msg_valid(msg_valid), .msg_data(msg_data));

   pscap_link_model link (.clk(clk), .nrst(nrst), .slow(slow), .msg_valid(msg_valid),
      .msg_data(msg_data), .msg_ready(msg_ready), .n_msg(n_msg), .last_msg(last_msg));

   // --------------------------------------------------------------
   // helpers
   // --------------------------------------------------------------
   initial
   begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic report_and_stop;
      if (err_count == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop

   // value/scale always writable, the rest only when unlocked
   function automatic logic [31:0] calc(input logic [31:0] old, input logic [31:0] d,
                                        input logic open);
      logic [31:0] r;
      r = open ? d : old;
      r[16:7] = d[16:7];
      r[18] = 1'h0;
      return r;
   endfunction : calc

   task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'h1;
      @(posedge clk);
      wr    <= 1'h0;
   endtask : wr_reg

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd   <= 1'h1;
      @(posedge clk);
      rd   <= 1'h0;
      #1;
      chk(rdata, exp);
      @(posedge clk);
      #1;
      chk(rdata, 32'h0000_0000);
   endtask : rd_chk

   task automatic wait_msg;
      int k;
      k = 0;
      while (n_msg <= n0 && k < 60)
      begin
         @(posedge clk);
         k++;
      end
      chk(32'(n_msg > n0), 32'h0000_0001);
      chk(32'(last_msg), 32'(mdl[16:7]));
   endtask : wait_msg

   task automatic wr_cap(input logic [31:0] d, input logic open);
      n0 = n_msg;
      wr_reg(pscap_pkg::CAP_OFF, d);
      mdl = calc(mdl, d, open);
      wait_msg();
      rd_chk(pscap_pkg::CAP_OFF, mdl);
   endtask : wr_cap

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         report_and_stop();
      end
   end

   // --------------------------------------------------------------
   // main sequence
   // --------------------------------------------------------------
   initial
   begin
      seed = 47575;
      nrst = 1'h0;
      addr = 12'h000;
      wdata = 32'h0000_0000;
      wr = 1'h0;
      rd = 1'h0;
      slot = 1'h0;
      cfg = 1'h0;
      dl = 1'h0;
      slow = 1'h0;
      mdl = 32'h0000_0000;
      repeat (10) @(posedge clk);
      nrst <= 1'h1;
      slot <= 1'h1;
      rd_chk(pscap_pkg::CAP_OFF, 32'h0000_0000);
      wr_cap(32'hFFFF_FFFF, 1'h0);
      cfg <= 1'h1;
      for (int i = 0; i < 8; i++)
      begin
         w = $random(seed);
         w[16:15] = i[1:0];
         slow <= i[0];
         wr_cap(w, 1'h1);
      end
      wr_cap(32'hFFFF_FFFF, 1'h1);
      wr_cap(32'h0007_FFFF, 1'h1);
      cfg <= 1'h0;
      wr_reg(pscap_pkg::CTL_OFF, 32'h0000_0001);
      rd_chk(pscap_pkg::CTL_OFF, 32'h0000_0001);
      rd_chk(pscap_pkg::STS_OFF, 32'h0000_0008);
      wr_cap($random(seed), 1'h1);
      wr_reg(pscap_pkg::CTL_OFF, 32'h0000_0000);
      slow <= 1'h1;
      // second write lands while the first message is out: two messages
      n0 = n_msg + 1;
      w = $random(seed);
      wr_reg(pscap_pkg::CAP_OFF, $random(seed));
      wr_reg(pscap_pkg::CAP_OFF, w);
      mdl = calc(mdl, w, 1'h0);
      wait_msg();
      repeat (20) @(posedge clk);
      chk(32'(last_msg), 32'(mdl[16:7]));
      chk(32'(msg_valid), 32'h0000_0000);
      chk(32'(n_msg), 32'(n0 + 1));
      slot <= 1'h0;
      rd_chk(pscap_pkg::CAP_OFF, 32'h0000_0000);
      n0 = n_msg;
      wr_reg(pscap_pkg::CAP_OFF, $random(seed));
      repeat (10) @(posedge clk);
      chk(32'(n_msg), 32'(n0));
      slot <= 1'h1;
      rd_chk(pscap_pkg::CAP_OFF, mdl);
      n0 = n_msg;
      dl <= 1'h1;
      wait_msg();
      rd_chk(12'h100, 32'h0000_0000);
      report_and_stop();
   end
endmodule : tb
